// ---- design/tkd_pkg.sv ----
`default_nettype none
package tkd_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int OPT_WINDOW_NS = 250_000;
  localparam int OPT_SAMPLES = 25;
  localparam int OPT_SPACING_CYC = OPT_WINDOW_NS / CLK_PERIOD_NS / OPT_SAMPLES;
  localparam logic [4:0] OPT_LAST = 5'h18;
  localparam logic [15:0] THRESH = 16'h000C;
  localparam logic [15:0] HYST = 16'h0002;
  localparam logic [15:0] NEG_DEV = 16'h0005;
  localparam logic [2:0] INTEG_LIMIT = 3'h6;
  localparam logic [15:0] TMO_10S_MS = 16'h2710;
  localparam logic [15:0] TMO_60S_MS = 16'hEA60;
  localparam logic [15:0] NEG_MS = 16'h07D0;
  localparam logic [15:0] OPT_PERIOD_MS = 16'h2710;
  localparam logic [15:0] DRIFT_DN_MS = 16'h0064;
  localparam logic [15:0] DRIFT_UP_MS = 16'h03E8;
  localparam logic [6:0] SLEEP_MS = 7'h5A;
  localparam logic [6:0] SYNC_MS = 7'h12;
  localparam logic [6:0] FAST_BURST_MS = 7'h06;
  localparam logic [6:0] FAST_STEP_MS = 7'h01;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_REF0 = 3'h4;
  localparam int CTRL_RECAL = 0;
  localparam int CTRL_SYNC_DIS = 1;
  localparam int PIN_RST = 0;
  localparam int PIN_SPEED = 1;
  localparam int PIN_TA = 2;
  localparam int PIN_TB = 3;
  localparam int PIN_SYNC = 4;
  typedef enum logic [1:0] {
    SMP_IDLE = 2'b01,
    SMP_RUN = 2'b10
  } tkd_smp_type;
  typedef struct packed {
    logic valid;
    logic [3:0][15:0] sig;
  } tkd_acq_type;
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tkd_bus_type;
endpackage
`default_nettype wire

// ---- design/tkd_top.sv ----
// Notes on behaviour
// - signal, reference and timer arithmetic is 16 bits wide
// - reference drifts toward signal when idle
// - per-channel one-count steps, thresholds follow reference
// - reference frozen during detection
// - falling signal tracked faster than rising
// - slow mode steps from 90 ms sleep
// - sync periods count as 18 ms
// - detect at reference plus 12 counts
// - release 2 counts below threshold
// - detection timer forces channel recalibration
// - timeout choices 10 s, 60 s, none
// - timeout recalibrates only its own channel
// - fast mode timing from clock cycles
// - slow sync timeouts counted as 18 ms
// - six acquisitions above threshold raise key
// - one miss clears integrator
// - confirming bursts run back to back in slow mode
// - power-up and reset release recalibrate all
// - 5 counts low for 2 s recalibrates
// - straps read at start, every 10 s idle
// - 25 agreeing samples over 250 us
// - sync used only in slow mode
// - strap pairs select timeout and toggle
// - toggle flips on rise, 10 s timeout kept
// - sync wakes burst, else 90 ms wake
//
// The register offsets and the strobed register port were chosen for this implementation.
`default_nettype none
module tkd_top #(
  parameter int MS_CYC = tkd_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // pins
  input wire logic recal_reset_n,
  input wire logic speed_strap,
  input wire logic timeout_strap_a,
  input wire logic timeout_strap_b,
  input wire logic sync_pin,
  // acquisition front end
  output logic burst_req,
  input wire tkd_pkg::tkd_acq_type acq,
  // key outputs
  output logic [3:0] key_out,
  // register port
  input wire tkd_pkg::tkd_bus_type bus,
  output logic [15:0] rdata
);
  typedef struct packed {
    logic [4:0] p1;
    logic [4:0] p2;
    logic [4:0] p3;
    logic [4:0] pf;
    logic [16:0] ms_cnt;
    logic ms_tick;
    logic [6:0] wake_ms;
    logic sync_on;
    logic burst_req;
    logic waiting;
    logic step_en;
    logic [6:0] step_ms;
    logic [15:0] up_ms;
    logic [15:0] dn_ms;
    logic up_due;
    logic dn_due;
    logic [3:0][15:0] refv;
    logic [3:0][15:0] dur;
    logic [3:0][15:0] neg;
    logic [3:0][2:0] integ;
    logic [3:0] neg_on;
    logic [3:0] act;
    logic [3:0] out;
    logic recal_all;
    tkd_pkg::tkd_smp_type smp;
    logic [9:0] smp_cyc;
    logic [4:0] smp_n;
    logic [2:0] smp_first;
    logic smp_bad;
    logic [15:0] opt_ms;
    logic opt_ok;
    logic slow;
    logic [1:0] tmo;
    logic sync_dis;
    logic [15:0] rdata;
  } tkd_state_type;

  logic [1:0] rst_sync_q;
  logic rst_n;
  tkd_state_type s_q;
  tkd_state_type s_d;
  logic [3:0] rc_w;
  logic toggle_w;
  logic [15:0] limit_w;

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    sat_add = t[16] ? 16'hFFFF : t[15:0];
  endfunction

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // strap decode on {b,a}: 10 is 10 s, 01 is 60 s, 11 toggle 10 s, 00 none
  always_comb begin
    toggle_w = (s_q.tmo == 2'b11);
    case (s_q.tmo)
      2'b10: limit_w = tkd_pkg::TMO_10S_MS;
      2'b01: limit_w = tkd_pkg::TMO_60S_MS;
      2'b11: limit_w = tkd_pkg::TMO_10S_MS;
      default: limit_w = 16'h0000;
    endcase
  end

  always_comb begin
    logic [4:0] pins;
    logic [15:0] th;
    logic [15:0] rel;
    logic [15:0] sig;
    logic burst;
    logic confirm;
    pins = '0;
    th = '0;
    rel = '0;
    sig = '0;
    burst = 1'b0;
    confirm = 1'b0;
    s_d = s_q;
    rc_w = '0;
    s_d.burst_req = 1'b0;
    s_d.step_en = 1'b0;
    s_d.rdata = 16'h0000;
    pins[tkd_pkg::PIN_RST] = recal_reset_n;
    pins[tkd_pkg::PIN_SPEED] = speed_strap;
    pins[tkd_pkg::PIN_TA] = timeout_strap_a;
    pins[tkd_pkg::PIN_TB] = timeout_strap_b;
    pins[tkd_pkg::PIN_SYNC] = sync_pin;
    s_d.p1 = pins;
    s_d.p2 = s_q.p1;
    s_d.p3 = s_q.p2;
    for (int b = 0; b < 5; b++) begin
      if (s_q.p2[b] == s_q.p3[b]) begin
        s_d.pf[b] = s_q.p3[b];
      end
    end
    // recalibrate all when the reset pin goes high again
    if (s_d.pf[tkd_pkg::PIN_RST] && !s_q.pf[tkd_pkg::PIN_RST]) begin
      s_d.recal_all = 1'b1;
    end

    // millisecond enable from the core clock
    s_d.ms_tick = 1'b0;
    if (s_q.ms_cnt == 17'(MS_CYC - 1)) begin
      s_d.ms_cnt = 17'h0_0000;
      s_d.ms_tick = 1'b1;
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 17'h0_0001;
    end

    // burst pacing and time steps
    if (s_q.opt_ok) begin
      if (s_q.slow) begin
        if (s_d.pf[tkd_pkg::PIN_SYNC] && !s_q.pf[tkd_pkg::PIN_SYNC] && !s_q.sync_dis) begin
          burst = 1'b1;
          s_d.wake_ms = 7'h00;
          s_d.sync_on = 1'b1;
          s_d.step_en = 1'b1;
          s_d.step_ms = tkd_pkg::SYNC_MS;
        end else if (s_q.ms_tick) begin
          if (s_q.wake_ms >= tkd_pkg::SLEEP_MS - 7'h01) begin
            burst = 1'b1;
            s_d.wake_ms = 7'h00;
            s_d.sync_on = 1'b0;
            s_d.step_en = 1'b1;
            s_d.step_ms = tkd_pkg::SLEEP_MS;
          end else begin
            s_d.wake_ms = s_q.wake_ms + 7'h01;
          end
        end
      end else begin
        s_d.sync_on = 1'b0;
        if (s_q.ms_tick) begin
          s_d.step_en = 1'b1;
          s_d.step_ms = tkd_pkg::FAST_STEP_MS;
          if (s_q.wake_ms >= tkd_pkg::FAST_BURST_MS - 7'h01) begin
            burst = 1'b1;
            s_d.wake_ms = 7'h00;
          end else begin
            s_d.wake_ms = s_q.wake_ms + 7'h01;
          end
        end
      end
    end

    // drift pacing, falling direction faster
    if (s_q.step_en) begin
      s_d.up_ms = sat_add(s_q.up_ms, {9'h000, s_q.step_ms});
      s_d.dn_ms = sat_add(s_q.dn_ms, {9'h000, s_q.step_ms});
      for (int i = 0; i < 4; i++) begin
        if (s_q.act[i]) begin
          s_d.dur[i] = sat_add(s_q.dur[i], {9'h000, s_q.step_ms});
        end
        if (s_q.neg_on[i]) begin
          s_d.neg[i] = sat_add(s_q.neg[i], {9'h000, s_q.step_ms});
        end
      end
    end

    // per-channel processing of one acquisition
    if (acq.valid) begin
      s_d.waiting = 1'b0;
      for (int i = 0; i < 4; i++) begin
        sig = acq.sig[i];
        th = sat_add(s_q.refv[i], tkd_pkg::THRESH);
        rel = th - tkd_pkg::HYST;
        rc_w[i] = s_q.recal_all
          || (s_q.act[i] && limit_w != 16'h0000 && s_q.dur[i] >= limit_w)
          || (s_q.neg[i] >= tkd_pkg::NEG_MS);
        if (rc_w[i]) begin
          s_d.refv[i] = sig;
          s_d.integ[i] = 3'h0;
          s_d.act[i] = 1'b0;
          s_d.dur[i] = 16'h0000;
          s_d.neg[i] = 16'h0000;
          s_d.neg_on[i] = 1'b0;
        end else begin
          if (s_q.act[i]) begin
            if (sig < rel) begin
              s_d.act[i] = 1'b0;
              s_d.integ[i] = 3'h0;
              s_d.dur[i] = 16'h0000;
            end
          end else if (sig > th) begin
            s_d.integ[i] = s_q.integ[i] + 3'h1;
            if (s_d.integ[i] == tkd_pkg::INTEG_LIMIT) begin
              s_d.act[i] = 1'b1;
            end else begin
              confirm = 1'b1;
            end
          end else begin
            s_d.integ[i] = 3'h0;
          end
          if (!s_q.act[i] && !s_d.act[i]) begin
            if (s_q.dn_due && sig < s_q.refv[i]) begin
              s_d.refv[i] = s_q.refv[i] - 16'h0001;
            end else if (s_q.up_due && sig > s_q.refv[i]) begin
              s_d.refv[i] = s_q.refv[i] + 16'h0001;
            end
          end
          s_d.neg_on[i] = (sat_add(sig, tkd_pkg::NEG_DEV) <= s_q.refv[i]);
          if (!s_d.neg_on[i]) begin
            s_d.neg[i] = 16'h0000;
          end
        end
      end
      s_d.recal_all = 1'b0;
      s_d.up_due = 1'b0;
      s_d.dn_due = 1'b0;
      // drift is frozen while a key is held, so a pending step is dropped
    end
    if (s_d.up_ms >= tkd_pkg::DRIFT_UP_MS) begin
      s_d.up_due = 1'b1;
      s_d.up_ms = 16'h0000;
    end
    if (s_d.dn_ms >= tkd_pkg::DRIFT_DN_MS) begin
      s_d.dn_due = 1'b1;
      s_d.dn_ms = 16'h0000;
    end
    if (s_d.pf[tkd_pkg::PIN_RST] && !s_q.pf[tkd_pkg::PIN_RST]) begin
      s_d.recal_all = 1'b1;
    end

    // key outputs: direct or toggle
    for (int i = 0; i < 4; i++) begin
      if (toggle_w) begin
        if (s_d.act[i] && !s_q.act[i]) begin
          s_d.out[i] = !s_q.out[i];
        end
      end else begin
        s_d.out[i] = s_d.act[i];
      end
    end

    if (acq.valid && confirm && s_q.slow) begin
      burst = 1'b1;
    end
    if (burst && !s_d.waiting) begin
      s_d.burst_req = 1'b1;
      s_d.waiting = 1'b1;
    end

    // strap sampler
    if (s_q.ms_tick && s_q.act == 4'h0) begin
      s_d.opt_ms = sat_add(s_q.opt_ms, 16'h0001);
    end
    case (s_q.smp)
      tkd_pkg::SMP_IDLE: begin
        if (!s_q.opt_ok || (s_q.opt_ms >= tkd_pkg::OPT_PERIOD_MS && s_q.act == 4'h0)) begin
          s_d.smp = tkd_pkg::SMP_RUN;
          s_d.smp_cyc = 10'h000;
          s_d.smp_n = 5'h00;
          s_d.smp_bad = 1'b0;
        end
      end
      tkd_pkg::SMP_RUN: begin
        if (s_q.smp_cyc == 10'(tkd_pkg::OPT_SPACING_CYC - 1)) begin
          s_d.smp_cyc = 10'h000;
          if (s_q.smp_n == 5'h00) begin
            s_d.smp_first = s_q.pf[3:1];
          end else if (s_q.pf[3:1] != s_q.smp_first) begin
            s_d.smp_bad = 1'b1;
          end
          if (s_q.smp_n == tkd_pkg::OPT_LAST) begin
            s_d.smp = tkd_pkg::SMP_IDLE;
            s_d.opt_ms = 16'h0000;
            if (!s_d.smp_bad) begin
              s_d.opt_ok = 1'b1;
              s_d.slow = s_d.smp_first[0];
              s_d.tmo = s_d.smp_first[2:1];
            end
          end else begin
            s_d.smp_n = s_q.smp_n + 5'h01;
          end
        end else begin
          s_d.smp_cyc = s_q.smp_cyc + 10'h001;
        end
      end
      default: s_d.smp = tkd_pkg::SMP_IDLE;
    endcase

    // register port
    if (bus.wr && bus.addr == tkd_pkg::REG_CTRL) begin
      s_d.sync_dis = bus.wdata[tkd_pkg::CTRL_SYNC_DIS];
      if (bus.wdata[tkd_pkg::CTRL_RECAL]) begin
        s_d.recal_all = 1'b1;
      end
    end
    if (bus.rd) begin
      case (bus.addr)
        tkd_pkg::REG_CTRL: s_d.rdata = {14'h0000, s_q.sync_dis, 1'b0};
        tkd_pkg::REG_STATUS: s_d.rdata = {2'b00, s_q.sync_on, s_q.opt_ok, toggle_w, s_q.tmo,
                                          s_q.slow, s_q.act, s_q.out};
        default: begin
          if (bus.addr >= tkd_pkg::REG_REF0) begin
            s_d.rdata = s_q.refv[bus.addr[1:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.p1 <= 5'h01;
      s_q.p2 <= 5'h01;
      s_q.p3 <= 5'h01;
      s_q.pf <= 5'h01;
      s_q.recal_all <= 1'b1;
      s_q.smp <= tkd_pkg::SMP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign burst_req = s_q.burst_req;
  assign key_out = s_q.out;
  assign rdata = s_q.rdata;

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence miss0_s;
    acq.valid && !s_q.act[0] && !(acq.sig[0] > sat_add(s_q.refv[0], tkd_pkg::THRESH));
  endsequence
  sequence held0_s;
    s_q.act[0] ##1 s_q.act[0];
  endsequence

  integ_clear_a: assert property (miss0_s |=> s_q.integ[0] == 3'h0)
    else $error("integrator not cleared on a miss");
  six_count_a: assert property ($rose(s_q.act[0]) |-> $past(s_q.integ[0]) == 3'h5)
    else $error("key rose without six detections");
  ref_frozen_a: assert property (held0_s |-> $stable(s_q.refv[0]))
    else $error("reference moved during detection");
  ref_step_a: assert property ($changed(s_q.refv[0]) && !$past(rc_w[0])
    |-> (s_q.refv[0] - $past(s_q.refv[0]) == 16'h0001) || ($past(s_q.refv[0]) - s_q.refv[0] == 16'h0001))
    else $error("reference step larger than one count");
  timeout_recal_a: assert property (acq.valid && s_q.act[0] && limit_w != 16'h0000 && s_q.dur[0] >= limit_w
    |=> !s_q.act[0] && s_q.refv[0] == $past(acq.sig[0]))
    else $error("timeout did not recalibrate channel");
  toggle_flip_a: assert property (toggle_w && $rose(s_q.act[1]) |-> s_q.out[1] != $past(s_q.out[1]))
    else $error("toggle output did not flip");
  direct_out_a: assert property (!toggle_w ##1 !toggle_w |-> s_q.out == s_q.act)
    else $error("direct output differs from detection");
  fast_step_a: assert property (s_q.step_en && !s_q.slow |-> s_q.step_ms == tkd_pkg::FAST_STEP_MS)
    else $error("sync influenced fast mode timing");
  opt_count_a: assert property ($rose(s_q.opt_ok) |-> $past(s_q.smp_n) == tkd_pkg::OPT_LAST)
    else $error("options accepted before all samples");
  pin_recal_a: assert property ($rose(s_q.pf[tkd_pkg::PIN_RST]) |-> s_q.recal_all)
    else $error("reset release did not request recalibration");
endmodule
`default_nettype wire

// ---- verif/tkd_front_model.sv ----
`default_nettype none
module tkd_front_model (
  // clock
  input wire logic clock,
  // handshake with the block
  input wire logic burst_req,
  output var tkd_pkg::tkd_acq_type acq,
  // electrode levels and answer speed
  input wire logic [3:0][15:0] sig_in,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_q = 1'b0;
  logic [3:0] wait_q = 4'h0;
  always @(posedge clock) begin
    acq.valid <= 1'b0;
    // counts wander every cycle between answers
    acq.sig <= ~acq.sig;
    if (busy_q) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h0) begin
        busy_q <= 1'b0;
        acq.valid <= 1'b1;
        acq.sig <= sig_in;
      end
    end else if (burst_req) begin
      busy_q <= 1'b1;
      wait_q <= slow ? 4'h8 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tkd_top_tb.sv ----
`default_nettype none
module tkd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic recal_reset_n = 1'b1;
  logic slow = 1'b0;
  logic burst_req;
  logic [3:0] key_out;
  logic [15:0] rdata;
  logic [3:0][15:0] sig;
  logic [15:0] base [4] = '{16'h1000, 16'h1100, 16'h1200, 16'h1300};
  tkd_pkg::tkd_acq_type acq;
  tkd_pkg::tkd_bus_type bus = '0;
  int n_errors = 0;
  int n_tests = 0;

  initial begin
    forever #5 clock = ~clock;
  end

  // 4 ms-cycles per ms keeps the 10 s timeout inside the run
  tkd_top #(.MS_CYC(4)) uut (.clock(clock), .arst_n(arst_n), .recal_reset_n(recal_reset_n),
    .speed_strap(1'b0), .timeout_strap_a(1'b0), .timeout_strap_b(1'b1), .sync_pin(1'b0),
    .burst_req(burst_req), .acq(acq), .key_out(key_out), .bus(bus), .rdata(rdata));

  tkd_front_model fm (.clock(clock), .burst_req(burst_req), .acq(acq), .sig_in(sig), .slow(slow));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic ref_is(input int c, input logic [15:0] e);
    logic [15:0] d;
    rd(tkd_pkg::REG_REF0 + 3'(c), d);
    chk(d, e);
  endtask

  // waits for n answers, then lets the key update land
  task automatic acqs(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clock);
        #1 k++;
      end while (acq.valid !== 1'b1 && k < 200);
      chk(16'(k < 200), 16'h0001);
    end
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic t_regs;
    logic [15:0] d;
    repeat (25300) @(posedge clock);
    for (int c = 0; c < 4; c++) ref_is(c, base[c]);
    rd(tkd_pkg::REG_STATUS, d);
    chk(d & 16'h3FFF, 16'h1400);
    @(posedge clock);
    #1 chk(rdata, 16'h0000);
    wr(tkd_pkg::REG_CTRL, 16'h0002);
    rd(tkd_pkg::REG_CTRL, d);
    chk(d, 16'h0002);
    wr(tkd_pkg::REG_REF0, 16'hFFFF);
    ref_is(0, base[0]);
    rd(3'h2, d);
    chk(d, 16'h0000);
    wr(tkd_pkg::REG_CTRL, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_integ;
    slow = 1'b1;
    acqs(1);
    sig[0] = base[0] + 16'h000D;
    acqs(3);
    sig[0] = base[0] + 16'h000C;
    acqs(1);
    sig[0] = base[0] + 16'h000D;
    acqs(5);
    chk(16'(key_out), 16'h0000);
    acqs(1);
    chk(16'(key_out), 16'h0001);
    slow = 1'b0;
    $display("t_integ done");
  endtask

  task automatic t_hyst;
    sig[0] = base[0] + 16'h000A;
    acqs(2);
    chk(16'(key_out), 16'h0001);
    ref_is(0, base[0]);
    sig[0] = base[0] + 16'h0009;
    acqs(1);
    chk(16'(key_out), 16'h0000);
    sig[0] = base[0];
    $display("t_hyst done");
  endtask

  task automatic t_negdev;
    logic [15:0] d1;
    logic [15:0] d2;
    sig[2] = base[2] - 16'h0064;
    sig[1] = base[1] + 16'h000B;
    acqs(1);
    repeat (4000) @(posedge clock);
    rd(tkd_pkg::REG_REF0 + 3'h1, d1);
    rd(tkd_pkg::REG_REF0 + 3'h2, d2);
    chk(16'(d1 - base[1] < 16'h0002), 16'h0001);
    chk(16'(d2 <= base[2] - 16'h0005 && d2 > base[2] - 16'h0064), 16'h0001);
    sig[1] = base[1];
    repeat (4800) @(posedge clock);
    ref_is(2, base[2] - 16'h0064);
    chk(16'(key_out), 16'h0000);
    $display("t_negdev done");
  endtask

  task automatic t_timeout;
    sig[0] = base[0] + 16'h0014;
    acqs(6);
    chk(16'(key_out), 16'h0001);
    repeat (36000) @(posedge clock);
    chk(16'(key_out), 16'h0001);
    ref_is(0, base[0]);
    sig[1] = base[1] + 16'h0014;
    repeat (5000) @(posedge clock);
    chk(16'(key_out), 16'h0002);
    ref_is(0, base[0] + 16'h0014);
    ref_is(1, base[1]);
    $display("t_timeout done");
  endtask

  task automatic t_recal;
    sig[3] = base[3] + 16'h0014;
    acqs(7);
    chk(16'(key_out), 16'h000A);
    @(posedge clock);
    recal_reset_n <= 1'b0;
    repeat (1000) @(posedge clock);
    recal_reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    acqs(1);
    chk(16'(key_out), 16'h0000);
    ref_is(3, base[3] + 16'h0014);
    ref_is(1, base[1] + 16'h0014);
    sig[3] = base[3] + 16'h0028;
    acqs(7);
    chk(16'(key_out), 16'h0008);
    wr(tkd_pkg::REG_CTRL, 16'h0001);
    acqs(1);
    chk(16'(key_out), 16'h0000);
    ref_is(3, base[3] + 16'h0028);
    $display("t_recal done");
  endtask

  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge clock);
    n_errors++;
    print_verdict;
  end

  initial begin
    sig = {base[3], base[2], base[1], base[0]};
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_regs;
    t_integ;
    t_hyst;
    t_negdev;
    t_timeout;
    t_recal;
    print_verdict;
  end
endmodule
`default_nettype wire
